// ---- verilog/fifo_write_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_defines.svh"

module fifo_write_port (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                multiChanCfg,
    input  wire logic                clk100Cfg,
    input  wire logic                writeReqLow,
    input  wire logic [`DATA_W-1:0]  dataIn,
    input  wire logic [`LANE_W-1:0]  byteLaneValid,
    input  wire logic                intLow,
    output logic                     spaceAvailLow,
    output logic                     acceptAckLow,
    output logic      [7:0]          statusOut,
    output logic                     statusOe,
    output logic                     modeMulti,
    output logic                     busClk100,
    output logic      [7:0]          busClkMhz,
    output logic                     intAsserted,
    input  wire logic [`CHAN_N-1:0]  chanFree,
    output logic                     outValid,
    input  wire logic                outReady,
    output logic      [`DATA_W-1:0]  outData,
    output logic      [`LANE_W-1:0]  outLanes,
    output logic      [`CHAN_W-1:0]  outChan
);

    fifo_port_pkg::bus_state_t state_r;
    fifo_port_pkg::bus_state_t state_nxt;
    logic [`CHAN_W-1:0]        chan_r;
    logic [`CHAN_W-1:0]        chan_nxt;
    logic                      mode_r;
    logic                      mode_nxt;
    logic                      clkSel_r;
    logic                      clkSel_nxt;
    logic [3:0]                status_r;
    logic [3:0]                status_nxt;
    logic                      intMeta_r;
    logic                      intSync_r;
    logic                      intAct_r;
    logic [`CRED_W-1:0]        credit_r   [`CHAN_N];
    logic [`CRED_W-1:0]        credit_nxt [`CHAN_N];
    logic [`CHAN_N-1:0]        spaceOk;
    logic [`CHAN_N-1:0]        takeChan;
    logic                      bufInReady;
    logic                      capture;
    logic [`CHAN_W-1:0]        capChan;
    logic                      cmdValid;
    logic [`CHAN_W-1:0]        cmdChan;
    logic                      ackOn;
    logic [`BUF_W-1:0]         bufOut;

    // per-channel credit stands for that channel's downstream store;
    // a full skid buffer stalls every channel so no captured word is lost
    genvar gi;
    generate
        for (gi = 0; gi < `CHAN_N; gi = gi + 1) begin : g_chan
            assign spaceOk[gi]  = (credit_r[gi] != `CRED_W'(0)) && bufInReady;
            assign takeChan[gi] = capture && (capChan == `CHAN_W'(gi));
            always_comb begin
                credit_nxt[gi] = credit_r[gi];
                if (chanFree[gi] && !takeChan[gi]) begin
                    credit_nxt[gi] = credit_r[gi] + `CRED_W'(1);
                end else if (takeChan[gi] && !chanFree[gi]) begin
                    credit_nxt[gi] = credit_r[gi] - `CRED_W'(1);
                end
            end
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    credit_r[gi] <= `CHAN_DEPTH;
                end else begin
                    credit_r[gi] <= credit_nxt[gi];
                end
            end
        end
    endgenerate

    // command decode: the cycle in idle where write request first goes low
    assign cmdValid = (byteLaneValid == `CMD_WRITE)
                      && (dataIn[7:0] >= `CHAN_CODE_MIN)
                      && (dataIn[7:0] <= `CHAN_CODE_MAX);
    assign cmdChan  = dataIn[1:0] - `CHAN_W'(1);

    // acknowledge falls in the same cycle the channel's space runs out
    assign ackOn    = mode_r && (state_r == fifo_port_pkg::ST_DATA) && spaceOk[chan_r];

    always_comb begin
        capture = 1'b0;
        capChan = `CHAN_W'(0);
        if (mode_r == `MODE_SINGLE) begin
            capture = !writeReqLow && spaceOk[0];
        end else begin
            capture = !writeReqLow && ackOn;
            capChan = chan_r;
        end
    end

    always_comb begin
        state_nxt  = state_r;
        chan_nxt   = chan_r;
        mode_nxt   = mode_r;
        clkSel_nxt = clkSel_r;
        // configuration is taken only while the bus is quiet and empty
        if (state_r == fifo_port_pkg::ST_IDLE && writeReqLow && !outValid) begin
            mode_nxt   = multiChanCfg;
            clkSel_nxt = clk100Cfg;
        end
        case (state_r)
            fifo_port_pkg::ST_IDLE: begin
                if (mode_r == `MODE_MULTI && !writeReqLow) begin
                    // credit alone decides; a brief receiver stall must not refuse a command
                    if (cmdValid && (credit_r[cmdChan] != `CRED_W'(0))) begin
                        state_nxt = fifo_port_pkg::ST_DATA;
                        chan_nxt  = cmdChan;
                    end else begin
                        // reserved codes and full channels: sit out the request
                        state_nxt = fifo_port_pkg::ST_IGNORE;
                    end
                end
            end
            fifo_port_pkg::ST_DATA: begin
                if (writeReqLow) begin
                    state_nxt = fifo_port_pkg::ST_TURN;
                end
            end
            fifo_port_pkg::ST_TURN: begin
                state_nxt = fifo_port_pkg::ST_IDLE;
            end
            fifo_port_pkg::ST_IGNORE: begin
                if (writeReqLow) begin
                    state_nxt = fifo_port_pkg::ST_TURN;
                end
            end
            default: begin
                state_nxt = fifo_port_pkg::ST_IDLE;
            end
        endcase
        status_nxt = ~spaceOk;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r  <= fifo_port_pkg::ST_IDLE;
            chan_r   <= `CHAN_W'(0);
            mode_r   <= `MODE_SINGLE;
            clkSel_r <= `CLK_SEL_66;
            status_r <= `STATUS_IDLE_HI;
        end else begin
            state_r  <= state_nxt;
            chan_r   <= chan_nxt;
            mode_r   <= mode_nxt;
            clkSel_r <= clkSel_nxt;
            status_r <= status_nxt;
        end
    end

    // interrupt pin is asynchronous: two flops before anything reads it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            intMeta_r <= 1'b1;
            intSync_r <= 1'b1;
            intAct_r  <= 1'b0;
        end else begin
            intMeta_r <= intLow;
            intSync_r <= intMeta_r;
            intAct_r  <= !intSync_r;
        end
    end

    // bus pins: data lines are inputs only; the device drives just 15:8 status
    assign statusOe      = mode_r && (state_r == fifo_port_pkg::ST_IDLE);
    assign statusOut     = {`STATUS_IDLE_HI, status_r};
    assign spaceAvailLow = (mode_r == `MODE_SINGLE) ? !spaceOk[0]
                           : (state_r != fifo_port_pkg::ST_IDLE);
    assign acceptAckLow  = !ackOn;
    assign modeMulti     = mode_r;
    assign busClk100     = clkSel_r;
    assign busClkMhz     = clkSel_r ? `BUS_MHZ_100 : `BUS_MHZ_66;
    assign intAsserted   = intAct_r;

    two_entry_buffer u_buf (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (capture),
        .inReady  (bufInReady),
        .inData   ({byteLaneValid, capChan, dataIn}),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (bufOut)
    );

    assign outData  = bufOut[`DATA_W-1:0];
    assign outChan  = bufOut[`DATA_W+`CHAN_W-1:`DATA_W];
    assign outLanes = bufOut[`BUF_W-1:`DATA_W+`CHAN_W];

    a_single_flag: assert property (@(posedge clock) disable iff (!rst_n)
        (!mode_r && !spaceAvailLow) |-> (credit_r[0] != `CRED_W'(0) && bufInReady))
        else $error("space flag low without room");

    a_single_capture: assert property (@(posedge clock) disable iff (!rst_n)
        (!mode_r && !writeReqLow && !spaceAvailLow && !chanFree[0])
        |=> (credit_r[0] == $past(credit_r[0]) - `CRED_W'(1)))
        else $error("enabled write not captured");

    a_single_ack_high: assert property (@(posedge clock) disable iff (!rst_n)
        !mode_r |-> acceptAckLow)
        else $error("acknowledge driven in single mode");

    a_multi_status: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r && state_r != fifo_port_pkg::ST_IDLE) |-> spaceAvailLow)
        else $error("status valid outside idle");

    a_status_drive: assert property (@(posedge clock) disable iff (!rst_n)
        statusOe |-> (state_r == fifo_port_pkg::ST_IDLE && mode_r
                      && statusOut == {`STATUS_IDLE_HI, ~$past(spaceOk)}))
        else $error("status bus driven out of idle");

    a_ack_space: assert property (@(posedge clock) disable iff (!rst_n)
        !acceptAckLow |-> (state_r == fifo_port_pkg::ST_DATA && credit_r[chan_r] != `CRED_W'(0)))
        else $error("acknowledge without channel space");

    a_cmd_reject: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r && state_r == fifo_port_pkg::ST_IDLE && !writeReqLow && !cmdValid)
        |=> (state_r == fifo_port_pkg::ST_IGNORE && acceptAckLow))
        else $error("reserved command accepted");

    a_reset_clear: assert property (@(posedge clock)
        !rst_n |=> (state_r == fifo_port_pkg::ST_IDLE && mode_r == `MODE_SINGLE && !intAsserted))
        else $error("reset did not clear state");

    a_int_level: assert property (@(posedge clock) disable iff (!rst_n)
        !intSync_r |=> intAsserted)
        else $error("low interrupt pin not seen");

    a_cfg_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r != fifo_port_pkg::ST_IDLE) |=> ($stable(mode_r) && $stable(clkSel_r)))
        else $error("configuration changed mid transfer");

    a_no_data_drive: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == fifo_port_pkg::ST_DATA) |-> !statusOe)
        else $error("device drove data during transfer");

    a_cmd_accept: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r && state_r == fifo_port_pkg::ST_IDLE && !writeReqLow && cmdValid && credit_r[cmdChan] != `CRED_W'(0))
        |=> (state_r == fifo_port_pkg::ST_DATA && chan_r == $past(cmdChan)))
        else $error("valid command not taken");

    a_turn_idle: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == fifo_port_pkg::ST_TURN) |=> (state_r == fifo_port_pkg::ST_IDLE))
        else $error("turnaround not followed by idle");

    a_data_release: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == fifo_port_pkg::ST_DATA && writeReqLow) |=> (state_r == fifo_port_pkg::ST_TURN))
        else $error("released request did not end transfer");

    a_ignore_no_ack: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == fifo_port_pkg::ST_IGNORE) |-> acceptAckLow)
        else $error("acknowledge on ignored request");

    a_multi_capture: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r && !writeReqLow && !acceptAckLow && !chanFree[chan_r])
        |=> (credit_r[chan_r] == $past(credit_r[chan_r]) - `CRED_W'(1)))
        else $error("acknowledged word not captured");

    a_single_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !mode_r |-> (state_r == fifo_port_pkg::ST_IDLE))
        else $error("single mode left idle");

    a_int_clear: assert property (@(posedge clock) disable iff (!rst_n)
        intSync_r |=> !intAsserted)
        else $error("high interrupt pin seen as asserted");

    a_clk_load: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == fifo_port_pkg::ST_IDLE && writeReqLow && !outValid)
        |=> (busClk100 == $past(clk100Cfg) && modeMulti == $past(multiChanCfg)))
        else $error("configuration not loaded while idle");

    a_stall_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (!mode_r && !bufInReady) |-> spaceAvailLow)
        else $error("space flag low with full buffer");

    a_out_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (outValid && !outReady) |=> (outValid && $stable(outData) && $stable(outLanes) && $stable(outChan)))
        else $error("stalled output word changed");

    a_chan_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r != fifo_port_pkg::ST_IDLE) |=> $stable(chan_r))
        else $error("channel changed mid transfer");

endmodule : fifo_write_port

`default_nettype wire

// ---- verilog/fifo_port_defines.svh ----
`ifndef FIFO_PORT_DEFINES_SVH
`define FIFO_PORT_DEFINES_SVH

`define DATA_W          32
`define LANE_W          4
`define CHAN_N          4
`define CHAN_W          2
`define BUF_W           38
`define BUF_DEPTH       2
`define CRED_W          5
`define CHAN_DEPTH      5'h10
`define CMD_WRITE       4'h1
`define CHAN_CODE_MIN   8'h01
`define CHAN_CODE_MAX   8'h04
`define MODE_SINGLE     1'b0
`define MODE_MULTI      1'b1
`define CLK_SEL_66      1'b0
`define CLK_SEL_100     1'b1
`define BUS_MHZ_66      8'h42
`define BUS_MHZ_100     8'h64
`define STATUS_IDLE_HI  4'hF

`endif

// ---- verilog/fifo_port_pkg.sv ----
package fifo_port_pkg;

    // gray codes along idle -> data -> turnaround; the step from turnaround back to idle changes both bits
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_DATA   = 2'h1,
        ST_TURN   = 2'h3,
        ST_IGNORE = 2'h2
    } bus_state_t;

endpackage : fifo_port_pkg

// ---- verilog/two_entry_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_defines.svh"

module two_entry_buffer (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               inValid,
    output logic                    inReady,
    input  wire logic [`BUF_W-1:0]  inData,
    output logic                    outValid,
    input  wire logic               outReady,
    output logic      [`BUF_W-1:0]  outData
);

    logic [`BUF_W-1:0] mem_r [`BUF_DEPTH];
    logic              wrPtr_r;
    logic              wrPtr_nxt;
    logic              rdPtr_r;
    logic              rdPtr_nxt;
    logic [1:0]        count_r;
    logic [1:0]        count_nxt;
    logic              push;
    logic              pop;

    assign inReady  = (count_r != 2'h2);
    assign outValid = (count_r != 2'h0);
    assign outData  = mem_r[rdPtr_r];

    always_comb begin
        push      = inValid && inReady;
        pop       = outValid && outReady;
        wrPtr_nxt = wrPtr_r ^ push;
        rdPtr_nxt = rdPtr_r ^ pop;
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 2'h1;
        end else if (pop && !push) begin
            count_nxt = count_r - 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

endmodule : two_entry_buffer

`default_nettype wire

// ---- verif/bus_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_defines.svh"
module bus_master_model (
    input  wire logic               clock,
    input  wire logic               spaceAvailLow,
    input  wire logic               acceptAckLow,
    output var logic                writeReqLow,
    output var logic [`DATA_W-1:0]  dataIn,
    output var logic [`LANE_W-1:0]  byteLaneValid
);
    logic [37:0] expQ[$];
    int          taken = 0;
    initial begin
        writeReqLow = 1'b1;
        dataIn = 32'hFFFFFFFF;
        byteLaneValid = 4'hF;
    end
    // idle bus: master holds its lanes at ones
    task automatic idle();
        writeReqLow <= 1'b1;
        dataIn <= 32'hFFFFFFFF;
        byteLaneValid <= 4'hF;
    endtask : idle
    // each word is held until an edge finds the go signal low or 40 edges have passed
    task automatic push_words(input logic multi, input logic [1:0] ch, input int n);
        logic [31:0] d;
        logic [3:0]  l;
        int          w;
        taken = 0;
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            l = 4'($urandom);
            // slow master: single mode may pause, lines show the inverse meanwhile
            if (!multi && $urandom_range(3) == 0) begin
                writeReqLow <= 1'b1;
                dataIn <= ~dataIn;
                @(posedge clock);
            end
            writeReqLow <= 1'b0;
            dataIn <= d;
            byteLaneValid <= l;
            w = 0;
            do begin
                @(posedge clock);
                w++;
            end while ((multi ? acceptAckLow : spaceAvailLow) !== 1'b0 && w < 40);
            if ((multi ? acceptAckLow : spaceAvailLow) !== 1'b0) break;
            expQ.push_back({ch, l, d});
            taken++;
        end
        idle();
        @(posedge clock);
    endtask : push_words
    // command phase, data phase, then turnaround back to idle
    task automatic burst(input logic [7:0] code, input logic [3:0] cmd, input int n);
        writeReqLow <= 1'b0;
        byteLaneValid <= cmd;
        dataIn <= {24'hFFFFFF, code};
        @(posedge clock);
        push_words(1'b1, code[1:0] - 2'h1, n);
        repeat (2) @(posedge clock);
    endtask : burst
endmodule : bus_master_model
`default_nettype wire

// ---- verif/video_fifo_slave_write_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_port_defines.svh"
module video_fifo_slave_write_port_bench;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic              multiChanCfg = 1'b0;
    logic              clk100Cfg = 1'b0;
    logic              intLow = 1'b1;
    logic              outReady = 1'b1;
    logic [3:0]        chanFree = 4'h0;
    logic              writeReqLow, spaceAvailLow, acceptAckLow, statusOe, modeMulti, intAsserted, outValid;
    logic              busClk100;
    logic [31:0]       dataIn, outData;
    logic [3:0]        byteLaneValid, outLanes;
    logic [7:0]        statusOut, busClkMhz;
    logic [1:0]        outChan;
    logic [39:0]       expWord;
    logic [11:0]       bad[4] = '{12'h001, 12'h051, 12'h012, 12'hFF1};
    int unsigned       seed;
    int                miscompares = 0;
    int                comparisons = 0;
    int                cycles = 0;
    always #25 clock = ~clock;
    fifo_write_port uut (.clock(clock), .rst_n(rst_n), .multiChanCfg(multiChanCfg), .clk100Cfg(clk100Cfg),
        .writeReqLow(writeReqLow), .dataIn(dataIn), .byteLaneValid(byteLaneValid), .intLow(intLow),
        .spaceAvailLow(spaceAvailLow), .acceptAckLow(acceptAckLow), .statusOut(statusOut), .statusOe(statusOe),
        .modeMulti(modeMulti), .busClk100(busClk100), .busClkMhz(busClkMhz), .intAsserted(intAsserted),
        .chanFree(chanFree), .outValid(outValid), .outReady(outReady), .outData(outData),
        .outLanes(outLanes), .outChan(outChan));
    bus_master_model master (.clock(clock), .spaceAvailLow(spaceAvailLow), .acceptAckLow(acceptAckLow),
        .writeReqLow(writeReqLow), .dataIn(dataIn), .byteLaneValid(byteLaneValid));
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // credit back from the usb side, one word per pulse
    task automatic give(input int ch, input int n);
        repeat (n) begin
            chanFree <= 4'h1 << ch;
            @(posedge clock);
        end
        chanFree <= 4'h0;
    endtask : give
    // receiver stalls at random so the two-entry buffer fills
    always @(posedge clock) outReady <= 1'($urandom_range(1));
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
        if (rst_n === 1'b1 && outValid === 1'b1 && outReady === 1'b1) begin
            expWord = master.expQ.size() > 0 ? {2'h0, master.expQ.pop_front()} : 40'hFFFFFFFFFF;
            check({2'h0, outChan, outLanes, outData}, expWord);
        end
    end
    initial begin
        seed = $urandom(32'hD723);
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({modeMulti, busClkMhz, outValid, intAsserted}, {1'b0, `BUS_MHZ_66, 2'h0});
        check(acceptAckLow, 1'b1);
        check(busClk100, 1'b0);
        @(posedge clock);
        master.push_words(1'b0, 2'h0, 20);
        check(40'(master.taken), 40'h10);
        check(spaceAvailLow, 1'b1);
        give(0, 16);
        multiChanCfg <= 1'b1;
        clk100Cfg <= 1'b1;
        repeat (8) @(posedge clock);
        @(negedge clock);
        check({modeMulti, busClkMhz, statusOe, spaceAvailLow, statusOut}, {1'b1, 8'h64, 2'h2, 8'hF0});
        check({busClk100, busClkMhz}, {1'b1, `BUS_MHZ_100});
        @(posedge clock);
        for (int c = 1; c <= 4; c++) begin
            master.burst(8'(c), 4'h1, 3);
            check(40'(master.taken), 40'h3);
            give(c - 1, 3);
        end
        foreach (bad[i]) begin
            master.burst(bad[i][11:4], bad[i][3:0], 2);
            check(40'(master.taken), 40'h0);
        end
        fork
            master.burst(8'h03, 4'h1, 20);
            begin
                repeat (4) @(posedge clock);
                clk100Cfg <= 1'b0;
                repeat (3) @(posedge clock);
                check(busClkMhz, 8'h64);
                check(busClk100, 1'b1);
                clk100Cfg <= 1'b1;
            end
        join
        check(40'(master.taken), 40'h10);
        @(negedge clock);
        check(statusOut, 8'hF4);
        @(posedge clock);
        intLow <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        check(intAsserted, 1'b1);
        @(posedge clock);
        intLow <= 1'b1;
        while (master.expQ.size() != 0) @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({modeMulti, outValid, intAsserted, busClkMhz}, {3'h0, 8'h42});
        conclude();
    end
endmodule : video_fifo_slave_write_port_bench
`default_nettype wire
